// [pps_defs.vh]
// command codes, reset values and table sizes for the phase/protect bank
`ifndef PPS_DEFS_VH
`define PPS_DEFS_VH

`define PPS_CMD_OPERATION 8'h01
`define PPS_CMD_ON_OFF_CFG 8'h02
`define PPS_CMD_CHANNEL_SEL 8'h04
`define PPS_CMD_WRITE_LOCK 8'h10
`define PPS_CMD_NVM_SAVE 8'h15
`define PPS_CMD_VOUT_SETPOINT 8'h21

`define PPS_CHAN_ALL 8'hff
`define PPS_CHAN_RST 8'hff
`define PPS_CHAN_MAX 8'h03

`define PPS_LOCK_NONE 8'h00
`define PPS_LOCK_CFG 8'h20
`define PPS_LOCK_OPER 8'h40
`define PPS_LOCK_ALL 8'h80
`define PPS_LOCK_RST 8'h00

`define PPS_MEM_AW 4
`define PPS_MEM_LAST 4'hf
`define PPS_STORE_MAP 16'h7fff

`endif

// [pps_phase_check.v]
// phase index from straps and legality check for channel select writes
`timescale 1ns/1ps
module pps_phase_check
(
  clk,
  rst,
  follower_strap_pin,
  interleave_pos,
  strap_select_two_pos,
  use_interleave,
  phase_count,
  wr_value,
  value_ok_r,
  phase_index_r
);
`include "pps_defs.vh"
  input wire clk;
  input wire rst;
  input wire follower_strap_pin;
  input wire [1:0] interleave_pos;
  input wire [1:0] strap_select_two_pos;
  input wire use_interleave;
  input wire [2:0] phase_count;
  input wire [7:0] wr_value;
  output reg value_ok_r;
  output reg [7:0] phase_index_r;

  reg [7:0] index_nxt;
  reg ok_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    // controller always owns index zero
    index_nxt = 8'h00;
    if (follower_strap_pin)
    begin
      if (use_interleave)
        index_nxt = {6'h00, interleave_pos};
      else
        index_nxt = {6'h00, strap_select_two_pos};
    end
    ok_nxt = 1'b0;
    if (wr_value == `PPS_CHAN_ALL)
      ok_nxt = 1'b1;
    else if (wr_value <= `PPS_CHAN_MAX &&
             {5'h00, phase_count} > wr_value)
      ok_nxt = 1'b1;
    // 04h..feh falls through as invalid
  end

  ////////////////////////////////////////////////////////////////////////////
  // straps sampled every clock, so a strap change is seen one cycle later
  always @(posedge clk)
  begin
    if (rst)
    begin
      value_ok_r <= 1'b0;
      phase_index_r <= 8'h00;
    end
    else
    begin
      value_ok_r <= ok_nxt;
      phase_index_r <= index_nxt;
    end
  end
endmodule

// [pps_nvm_copier.v]
// walks operating memory and copies mapped items into user store
`timescale 1ns/1ps
module pps_nvm_copier
(
  clk,
  rst,
  start,
  op_rd_data,
  op_rd_addr_r,
  nvm_wr_en_r,
  nvm_wr_addr_r,
  nvm_wr_data_r,
  busy_r
);
`include "pps_defs.vh"
  input wire clk;
  input wire rst;
  input wire start;
  input wire [7:0] op_rd_data;
  output reg [`PPS_MEM_AW-1:0] op_rd_addr_r;
  output reg nvm_wr_en_r;
  output reg [`PPS_MEM_AW-1:0] nvm_wr_addr_r;
  output reg [7:0] nvm_wr_data_r;
  output reg busy_r;

  localparam ST_IDLE = 2'd0;
  localparam ST_READ = 2'd1;
  localparam ST_WRITE = 2'd2;

  reg [1:0] state_r;
  wire [15:0] store_map;

  assign store_map = `PPS_STORE_MAP;

  ////////////////////////////////////////////////////////////////////////////
  // one item per two cycles: address out, then read data back one cycle later
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      op_rd_addr_r <= 4'h0;
      nvm_wr_en_r <= 1'b0;
      nvm_wr_addr_r <= 4'h0;
      nvm_wr_data_r <= 8'h00;
      busy_r <= 1'b0;
    end
    else
    begin
      nvm_wr_en_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (start)
          begin
            op_rd_addr_r <= 4'h0;
            busy_r <= 1'b1;
            state_r <= ST_READ;
          end
        end
        ST_READ:
          state_r <= ST_WRITE;
        ST_WRITE:
        begin
          // items without a store slot are skipped
          nvm_wr_en_r <= store_map[op_rd_addr_r];
          nvm_wr_addr_r <= op_rd_addr_r;
          nvm_wr_data_r <= op_rd_data;
          if (op_rd_addr_r == `PPS_MEM_LAST)
          begin
            busy_r <= 1'b0;
            state_r <= ST_IDLE;
          end
          else
          begin
            op_rd_addr_r <= op_rd_addr_r + 4'h1;
            state_r <= ST_READ;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// [pps_cmd_bank.v]
// command handler for channel select, write lock and nvm save
`timescale 1ns/1ps
module pps_cmd_bank
(
  clk,
  rst,
  cmd_valid,
  cmd_write,
  cmd_code,
  cmd_data,
  follower_strap_pin,
  interleave_pos,
  strap_select_two_pos,
  use_interleave,
  phase_count,
  lock_boot_value,
  op_rd_data,
  cmd_done_r,
  cmd_ignored_r,
  rd_data_r,
  invalid_data_r,
  host_notify_r,
  write_blocked_r,
  fwd_valid_r,
  fwd_write_r,
  fwd_code_r,
  fwd_data_r,
  fwd_phase_r,
  channel_select_r,
  write_lock_level_r,
  phase_index_r,
  op_rd_addr_r,
  nvm_wr_en_r,
  nvm_wr_addr_r,
  nvm_wr_data_r,
  save_busy_r
);
`include "pps_defs.vh"
  input wire clk;
  input wire rst;
  input wire cmd_valid;
  input wire cmd_write;
  input wire [7:0] cmd_code;
  input wire [7:0] cmd_data;
  input wire follower_strap_pin;
  input wire [1:0] interleave_pos;
  input wire [1:0] strap_select_two_pos;
  input wire use_interleave;
  input wire [2:0] phase_count;
  input wire [7:0] lock_boot_value;
  input wire [7:0] op_rd_data;
  output reg cmd_done_r;
  output reg cmd_ignored_r;
  output reg [7:0] rd_data_r;
  output reg invalid_data_r;
  output reg host_notify_r;
  output reg write_blocked_r;
  output reg fwd_valid_r;
  output reg fwd_write_r;
  output reg [7:0] fwd_code_r;
  output reg [7:0] fwd_data_r;
  output reg [7:0] fwd_phase_r;
  output reg [7:0] channel_select_r;
  output reg [7:0] write_lock_level_r;
  output wire [7:0] phase_index_r;
  output wire [`PPS_MEM_AW-1:0] op_rd_addr_r;
  output wire nvm_wr_en_r;
  output wire [`PPS_MEM_AW-1:0] nvm_wr_addr_r;
  output wire [7:0] nvm_wr_data_r;
  output wire save_busy_r;

  localparam ST_IDLE = 2'd0;
  localparam ST_CHECK = 2'd1;
  localparam ST_SAVE = 2'd2;

  reg [1:0] state_r;
  reg boot_load_r;
  reg [7:0] held_data_r;
  reg save_start_r;
  reg save_start_nxt;
  reg write_ok;
  reg lock_value_ok;
  wire chan_ok_r;

  ////////////////////////////////////////////////////////////////////////////
  pps_phase_check u_phase_check
  (
    .clk(clk),
    .rst(rst),
    .follower_strap_pin(follower_strap_pin),
    .interleave_pos(interleave_pos),
    .strap_select_two_pos(strap_select_two_pos),
    .use_interleave(use_interleave),
    .phase_count(phase_count),
    .wr_value(cmd_data),
    .value_ok_r(chan_ok_r),
    .phase_index_r(phase_index_r)
  );

  pps_nvm_copier u_copier
  (
    .clk(clk),
    .rst(rst),
    .start(save_start_r),
    .op_rd_data(op_rd_data),
    .op_rd_addr_r(op_rd_addr_r),
    .nvm_wr_en_r(nvm_wr_en_r),
    .nvm_wr_addr_r(nvm_wr_addr_r),
    .nvm_wr_data_r(nvm_wr_data_r),
    .busy_r(save_busy_r)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write permission by lock level; lock register writable at the four defined levels, an undefined level blocks every write
  always @*
  begin
    write_ok = 1'b0;
    case (write_lock_level_r)
      `PPS_LOCK_NONE:
        write_ok = 1'b1;
      `PPS_LOCK_CFG:
        write_ok = (cmd_code == `PPS_CMD_WRITE_LOCK) ||
                   (cmd_code == `PPS_CMD_OPERATION) ||
                   (cmd_code == `PPS_CMD_ON_OFF_CFG) ||
                   (cmd_code == `PPS_CMD_NVM_SAVE) ||
                   (cmd_code == `PPS_CMD_VOUT_SETPOINT);
      `PPS_LOCK_OPER:
        write_ok = (cmd_code == `PPS_CMD_WRITE_LOCK) ||
                   (cmd_code == `PPS_CMD_OPERATION) ||
                   (cmd_code == `PPS_CMD_NVM_SAVE);
      `PPS_LOCK_ALL:
        write_ok = (cmd_code == `PPS_CMD_WRITE_LOCK) ||
                   (cmd_code == `PPS_CMD_NVM_SAVE);
      default:
        write_ok = 1'b0;
    endcase
    lock_value_ok = (cmd_data == `PPS_LOCK_NONE) ||
                    (cmd_data == `PPS_LOCK_CFG) ||
                    (cmd_data == `PPS_LOCK_OPER) ||
                    (cmd_data == `PPS_LOCK_ALL);
  end

  ////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    save_start_nxt = 1'b0;
    if (state_r == ST_IDLE && cmd_valid && cmd_write && write_ok &&
        cmd_code == `PPS_CMD_NVM_SAVE)
      // no regulation check: saving live is discouraged, not prevented
      save_start_nxt = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      boot_load_r <= 1'b1;
      held_data_r <= 8'h00;
      save_start_r <= 1'b0;
      cmd_done_r <= 1'b0;
      cmd_ignored_r <= 1'b0;
      rd_data_r <= 8'h00;
      invalid_data_r <= 1'b0;
      host_notify_r <= 1'b0;
      write_blocked_r <= 1'b0;
      fwd_valid_r <= 1'b0;
      fwd_write_r <= 1'b0;
      fwd_code_r <= 8'h00;
      fwd_data_r <= 8'h00;
      fwd_phase_r <= `PPS_CHAN_RST;
      channel_select_r <= `PPS_CHAN_RST;
      write_lock_level_r <= `PPS_LOCK_RST;
    end
    else
    begin
      cmd_done_r <= 1'b0;
      cmd_ignored_r <= 1'b0;
      invalid_data_r <= 1'b0;
      host_notify_r <= 1'b0;
      write_blocked_r <= 1'b0;
      fwd_valid_r <= 1'b0;
      save_start_r <= save_start_nxt;
      boot_load_r <= 1'b0;
      // lock level comes from nvm once, the cycle after reset release
      if (boot_load_r)
        write_lock_level_r <= lock_boot_value;
      case (state_r)
        ST_IDLE:
        begin
          if (cmd_valid && !boot_load_r)
          begin
            if (!cmd_write)
            begin
              // reads never checked against the lock level
              cmd_done_r <= 1'b1;
              if (cmd_code == `PPS_CMD_CHANNEL_SEL)
                rd_data_r <= channel_select_r;
              else if (cmd_code == `PPS_CMD_WRITE_LOCK)
                rd_data_r <= write_lock_level_r;
              else if (cmd_code == `PPS_CMD_NVM_SAVE)
              begin
                rd_data_r <= 8'h00;
                invalid_data_r <= 1'b1;
                host_notify_r <= 1'b1;
              end
              else
              begin
                rd_data_r <= 8'h00;
                fwd_valid_r <= 1'b1;
                fwd_write_r <= 1'b0;
                fwd_code_r <= cmd_code;
                fwd_data_r <= 8'h00;
                fwd_phase_r <= channel_select_r;
              end
            end
            else if (!write_ok)
            begin
              // blocked write leaves every stored value alone
              cmd_done_r <= 1'b1;
              write_blocked_r <= 1'b1;
              host_notify_r <= 1'b1;
            end
            else if (cmd_code == `PPS_CMD_CHANNEL_SEL)
            begin
              // legality is registered in the checker, decided next cycle
              held_data_r <= cmd_data;
              state_r <= ST_CHECK;
            end
            else if (cmd_code == `PPS_CMD_WRITE_LOCK)
            begin
              cmd_done_r <= 1'b1;
              if (lock_value_ok)
                write_lock_level_r <= cmd_data;
              else
              begin
                invalid_data_r <= 1'b1;
                host_notify_r <= 1'b1;
              end
            end
            else if (cmd_code == `PPS_CMD_NVM_SAVE)
            begin
              cmd_done_r <= 1'b1;
              state_r <= ST_SAVE;
            end
            else
            begin
              cmd_done_r <= 1'b1;
              fwd_valid_r <= 1'b1;
              fwd_write_r <= 1'b1;
              fwd_code_r <= cmd_code;
              fwd_data_r <= cmd_data;
              fwd_phase_r <= channel_select_r;
            end
          end
          else if (cmd_valid)
            cmd_ignored_r <= 1'b1;
        end
        ST_CHECK:
        begin
          cmd_done_r <= 1'b1;
          if (chan_ok_r)
            channel_select_r <= held_data_r;
          else
          begin
            invalid_data_r <= 1'b1;
            host_notify_r <= 1'b1;
          end
          if (cmd_valid)
            cmd_ignored_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        ST_SAVE:
        begin
          // commands arriving mid-save are dropped, not queued
          if (cmd_valid)
            cmd_ignored_r <= 1'b1;
          if (!save_start_r && !save_busy_r)
            state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// [pps_cmd_bank_monitor.sv]
// assertion checker for the phase/protect/save command bank
`timescale 1ns/1ps
`include "pps_defs.vh"
module pps_cmd_bank_monitor
(
  input wire clk,
  input wire rst,
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire follower_strap_pin,
  input wire [1:0] interleave_pos,
  input wire [1:0] strap_select_two_pos,
  input wire use_interleave,
  input wire [2:0] phase_count,
  input wire cmd_done_r,
  input wire cmd_ignored_r,
  input wire [7:0] rd_data_r,
  input wire invalid_data_r,
  input wire host_notify_r,
  input wire write_blocked_r,
  input wire [7:0] channel_select_r,
  input wire [7:0] write_lock_level_r,
  input wire [7:0] phase_index_r,
  input wire nvm_wr_en_r,
  input wire [`PPS_MEM_AW-1:0] nvm_wr_addr_r,
  input wire save_busy_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  a_sel_reset: assert property ($past(rst) |-> channel_select_r == 8'hff)
    else $error("channel select not all-phases after reset");
  a_sel_legal: assert property (channel_select_r <= 8'h03 ||
    channel_select_r == 8'hff) else $error("illegal channel select held");
  a_sel_count: assert property (channel_select_r != 8'hff |->
    channel_select_r < {5'h00, phase_count}) else $error("phase beyond config");
  // the boot load from nvm is exempt: only host writes are checked here
  a_lock_legal: assert property (!$past(rst, 2) &&
    $changed(write_lock_level_r) |->
    write_lock_level_r inside {8'h00, 8'h20, 8'h40, 8'h80})
    else $error("illegal lock level stored");
  a_ctrl_index: assert property (!follower_strap_pin [*3] |->
    phase_index_r == 8'h00) else $error("controller index not zero");
  a_follow_index: assert property ((follower_strap_pin &&
    $stable({use_interleave, interleave_pos, strap_select_two_pos})) [*3]
    |-> phase_index_r == {6'h00, use_interleave ? interleave_pos :
    strap_select_two_pos}) else $error("follower index wrong");
  a_refuse_keep: assert property (write_blocked_r || invalid_data_r |->
    $stable(channel_select_r) && $stable(write_lock_level_r))
    else $error("refused write changed a register");
  a_refuse_flag: assert property (invalid_data_r || write_blocked_r |->
    host_notify_r && cmd_done_r) else $error("refusal without notify");
  a_read_answer: assert property (cmd_valid && !cmd_write &&
    cmd_code == 8'h04 |=> cmd_ignored_r or
    (cmd_done_r && rd_data_r == $past(channel_select_r)))
    else $error("read of channel select wrong");
  a_save_start: assert property (cmd_valid && cmd_write &&
    cmd_code == 8'h15 |=> cmd_ignored_r or write_blocked_r or
    (cmd_done_r ##1 save_busy_r)) else $error("save did not start");
  a_save_end: assert property ($rose(save_busy_r) |->
    ##[1:40] !save_busy_r) else $error("save copy too long");
  a_store_map: assert property (nvm_wr_en_r |->
    nvm_wr_addr_r != 4'hf) else $error("unmapped item stored");
  c_save: cover property ($rose(save_busy_r));
  c_invalid: cover property (invalid_data_r);
  c_blocked: cover property (write_blocked_r);
endmodule

// [pps_host_model.sv]
// host model issuing single-byte commands to the bank
`timescale 1ns/1ps
module pps_host_model
(
  input wire clk,
  input wire cmd_done_r,
  input wire cmd_ignored_r,
  output reg cmd_valid,
  output reg cmd_write,
  output reg [7:0] cmd_code,
  output reg [7:0] cmd_data
);
  integer n;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_data = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // one request, then a wait of at most 8 cycles for the answer before the next request
  task xfer(input reg w, input reg [7:0] code, input reg [7:0] data);
    begin
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_code = code;
      cmd_data = data;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      // released lines do not keep the last value
      cmd_code = ~code;
      cmd_data = ~data;
      n = 0;
      while (cmd_done_r !== 1'b1 && cmd_ignored_r !== 1'b1 && n < 8)
      begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
    end
  endtask
endmodule

// [tb_top.sv]
// self-checking bench for the phase/protect/save command bank
`timescale 1ns/1ps
`include "pps_defs.vh"
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg follower_strap_pin = 1'b0;
  reg [1:0] interleave_pos = 2'h2;
  reg [1:0] strap_select_two_pos = 2'h3;
  reg use_interleave = 1'b1;
  reg [2:0] phase_count = 3'h4;
  reg [7:0] lock_boot_value = 8'h20;
  reg [7:0] op_rd_data = 8'h00;
  wire cmd_valid, cmd_write, cmd_done_r, cmd_ignored_r, invalid_data_r;
  wire host_notify_r, write_blocked_r, save_busy_r, nvm_wr_en_r;
  wire [7:0] cmd_code, cmd_data, rd_data_r, channel_select_r;
  wire [7:0] write_lock_level_r, phase_index_r, nvm_wr_data_r;
  wire [7:0] fwd_code_r, fwd_phase_r;
  wire [`PPS_MEM_AW-1:0] op_rd_addr_r, nvm_wr_addr_r;
  integer n_fail = 0, n_checks = 0, n_store = 0, i, j;
  reg [7:0] exp_chan, lv, cd;
  reg bad;
  always #5 clk = ~clk;
  pps_host_model i_pps_host_model (.clk(clk), .cmd_done_r(cmd_done_r),
    .cmd_ignored_r(cmd_ignored_r), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_data(cmd_data));
  pps_cmd_bank i_pps_cmd_bank (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .follower_strap_pin(follower_strap_pin), .interleave_pos(interleave_pos),
    .strap_select_two_pos(strap_select_two_pos),
    .use_interleave(use_interleave), .phase_count(phase_count),
    .lock_boot_value(lock_boot_value), .op_rd_data(op_rd_data),
    .cmd_done_r(cmd_done_r), .cmd_ignored_r(cmd_ignored_r),
    .rd_data_r(rd_data_r), .invalid_data_r(invalid_data_r),
    .host_notify_r(host_notify_r), .write_blocked_r(write_blocked_r),
    .fwd_valid_r(), .fwd_write_r(), .fwd_code_r(fwd_code_r), .fwd_data_r(),
    .fwd_phase_r(fwd_phase_r), .channel_select_r(channel_select_r),
    .write_lock_level_r(write_lock_level_r), .phase_index_r(phase_index_r),
    .op_rd_addr_r(op_rd_addr_r), .nvm_wr_en_r(nvm_wr_en_r),
    .nvm_wr_addr_r(nvm_wr_addr_r), .nvm_wr_data_r(nvm_wr_data_r),
    .save_busy_r(save_busy_r));
  ////////////////////////////////////////////////////////////////////////
  // operating memory: one cycle read latency, content tied to address
  always @(posedge clk)
    op_rd_data <= {4'ha, op_rd_addr_r};
  always @(posedge clk)
    if (nvm_wr_en_r === 1'b1)
    begin
      n_store = n_store + 1;
      chk8(nvm_wr_data_r, {4'ha, nvm_wr_addr_r});
    end
  task chk8(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task chk1(input got, input exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task hx(input reg w, input reg [7:0] c, input reg [7:0] d);
    i_pps_host_model.xfer(w, c, d);
  endtask
  function ok_wr(input [7:0] l, input [7:0] c);
    case (l)
      8'h00: ok_wr = 1'b1;
      8'h20: ok_wr = c == 8'h10 || c == 8'h01 || c == 8'h02 ||
        c == 8'h21 || c == 8'h15;
      8'h40: ok_wr = c == 8'h10 || c == 8'h01 || c == 8'h15;
      default: ok_wr = c == 8'h10 || c == 8'h15;
    endcase
  endfunction
  task print_verdict;
    begin
      $display("checks=%0d fails=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    n_fail = n_fail + 1;
    print_verdict;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk8(channel_select_r, 8'hff);
    chk8(write_lock_level_r, 8'h20);
    exp_chan = 8'hff;
    for (i = 0; i < 4; i = i + 1)
    begin
      lv = (i == 3) ? 8'h00 : (8'h20 << i);
      hx(1'b1, 8'h10, lv);
      chk8(write_lock_level_r, lv);
      for (j = 0; j < 4; j = j + 1)
      begin
        cd = (j == 0) ? 8'h01 : (j == 1) ? 8'h02 : (j == 2) ? 8'h21 : 8'h04;
        hx(1'b1, cd, 8'h01);
        chk1(write_blocked_r, !ok_wr(lv, cd));
        if (cd == 8'h04 && ok_wr(lv, cd))
          exp_chan = 8'h01;
        if (cd != 8'h04 && ok_wr(lv, cd))
        begin
          chk8(fwd_code_r, cd);
          chk8(fwd_phase_r, exp_chan);
        end
        chk8(channel_select_r, exp_chan);
        hx(1'b0, 8'h04, 8'h00);
        chk8(rd_data_r, exp_chan);
      end
    end
    hx(1'b1, 8'h10, 8'h33);
    chk1(invalid_data_r, 1'b1);
    chk8(write_lock_level_r, 8'h00);
    phase_count = 3'h3;
    for (i = 0; i < 6; i = i + 1)
    begin
      cd = (i == 0) ? 8'h00 : (i == 1) ? 8'h02 : (i == 2) ? 8'h03 :
        (i == 3) ? 8'h04 : (i == 4) ? 8'hfe : 8'hff;
      hx(1'b1, 8'h04, cd);
      bad = cd >= 8'h03 && cd != 8'hff;
      chk1(invalid_data_r, bad);
      if (!bad)
        exp_chan = cd;
      chk8(channel_select_r, exp_chan);
    end
    chk8(phase_index_r, 8'h00);
    follower_strap_pin = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk8(phase_index_r, 8'h02);
    use_interleave = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk8(phase_index_r, 8'h03);
    hx(1'b1, 8'h10, 8'h80);
    hx(1'b1, 8'h15, 8'h00);
    chk1(write_blocked_r, 1'b0);
    hx(1'b0, 8'h04, 8'h00);
    chk1(cmd_ignored_r, 1'b1);
    for (i = 0; i < 100 && save_busy_r !== 1'b0; i = i + 1)
      @(posedge clk);
    // host holds off a little after the copy ends
    repeat (3) @(posedge clk);
    #1;
    chk1(save_busy_r, 1'b0);
    chk8(n_store[7:0], 8'h0f);
    print_verdict;
  end
endmodule
bind pps_cmd_bank pps_cmd_bank_monitor i_pps_cmd_bank_monitor (.clk(clk),
  .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_code(cmd_code), .follower_strap_pin(follower_strap_pin),
  .interleave_pos(interleave_pos),
  .strap_select_two_pos(strap_select_two_pos),
  .use_interleave(use_interleave), .phase_count(phase_count),
  .cmd_done_r(cmd_done_r), .cmd_ignored_r(cmd_ignored_r),
  .rd_data_r(rd_data_r), .invalid_data_r(invalid_data_r),
  .host_notify_r(host_notify_r), .write_blocked_r(write_blocked_r),
  .channel_select_r(channel_select_r),
  .write_lock_level_r(write_lock_level_r), .phase_index_r(phase_index_r),
  .nvm_wr_en_r(nvm_wr_en_r), .nvm_wr_addr_r(nvm_wr_addr_r),
  .save_busy_r(save_busy_r));
